/* gpcn_pkg.sv */
// Operation
// - Direction bit 1 disables the driver; 0 drives the latched value.
// - Reset sets all direction bits so every pin is an input.
// - Output latch reads back its contents; writes update it.
// - Pin level reads return pins; writes to it update the latch.
// - Open-drain bit makes the pin drive low only, release for high.
// - Analog input needs analog-select and direction set; digital needs select clear.
// - Analog-select resets to all ones across its 16 bits.
// - Analog input pins read as 0 in the pin level register.
// - Output with analog-select set still drives the latched level.
// - Change detection works without clocks and raises an interrupt request; here pins are sampled on i_core_clk, so it needs the clock.
// - Change enable bit allows a pin change to raise the interrupt.
// - Change status records change since last pin level read; read re-arms.
// - Independent weak pull-up and pull-down enables per pin.
// - Set, clear and invert aliases change only bits written as 1.
// - Alias reads return undefined; here they read as zero.
`default_nettype none
package gpcn_pkg;
  localparam int unsigned      PORT_W      = 16;
  localparam logic [15:0]      DIR_RST     = 16'hffff;
  localparam logic [15:0]      ANSEL_RST   = 16'hffff;
  localparam logic [15:0]      ZERO_RST    = 16'h0000;
  // Register select codes
  localparam logic [2:0]       SEL_DIR     = 3'h0;
  localparam logic [2:0]       SEL_LAT     = 3'h1;
  localparam logic [2:0]       SEL_PORT    = 3'h2;
  localparam logic [2:0]       SEL_ODC     = 3'h3;
  localparam logic [2:0]       SEL_ANSEL   = 3'h4;
  localparam logic [2:0]       SEL_CNEN    = 3'h5;
  localparam logic [2:0]       SEL_PU      = 3'h6;
  localparam logic [2:0]       SEL_PD      = 3'h7;
  // Write operation codes
  localparam logic [1:0]       OP_WRITE    = 2'h0;
  localparam logic [1:0]       OP_CLR      = 2'h1;
  localparam logic [1:0]       OP_SET      = 2'h2;
  localparam logic [1:0]       OP_INV      = 2'h3;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        alias_rd;
    logic [2:0]  sel;
    logic [1:0]  op;
    logic [15:0] wdata;
  } gpcn_req_t;
endpackage
`default_nettype wire

/* gpcn_bitop.sv */
`timescale 1ns/100ps
`default_nettype none
module gpcn_bitop (
  input  wire logic [1:0]  i_op,    // Write operation
  input  wire logic [15:0] i_cur,   // Current register value
  input  wire logic [15:0] i_wdata, // Written data
  output logic      [15:0] o_next   // Resulting value
);
  always_comb begin
    case (i_op)
      gpcn_pkg::OP_CLR: o_next = i_cur & ~i_wdata;
      gpcn_pkg::OP_SET: o_next = i_cur | i_wdata;
      gpcn_pkg::OP_INV: o_next = i_cur ^ i_wdata;
      default:          o_next = i_wdata;
    endcase
  end
endmodule
`default_nettype wire

/* gpcn_port.sv */
`timescale 1ns/100ps
`default_nettype none
module gpcn_port (
  input  wire logic                i_core_clk,  // 50 MHz clock
  input  wire logic                i_rstn,      // Async reset, active low
  input  wire gpcn_pkg::gpcn_req_t i_req,       // Register access
  input  wire logic [15:0]         i_pin_in,    // Pin levels
  output logic      [15:0]         o_pin_out,   // Pin output value
  output logic      [15:0]         o_pin_oe,    // Pin drive enable
  output logic      [15:0]         o_rdata,     // Read data, valid cycle after rd
  output logic      [15:0]         o_pullup_en, // Weak pull-up enables
  output logic      [15:0]         o_pulldn_en, // Weak pull-down enables
  output logic      [15:0]         o_analog_in, // Pins in analog input mode
  output logic      [15:0]         o_change_status, // Change status flags
  output logic                     o_change_irq // Change interrupt request
);
  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [15:0] direction_reg;
  logic [15:0] output_latch_reg;
  logic [15:0] open_drain_ctl_reg;
  logic [15:0] analog_select_reg;
  logic [15:0] change_irq_enable_reg;
  logic [15:0] weak_pullup_enable_reg;
  logic [15:0] weak_pulldown_enable_reg;
  logic [15:0] cur_val;
  logic [15:0] next_val;
  logic        wr_dir;
  logic        wr_lat;

  always_comb begin
    case (i_req.sel)
      gpcn_pkg::SEL_DIR:   cur_val = direction_reg;
      gpcn_pkg::SEL_LAT:   cur_val = output_latch_reg;
      gpcn_pkg::SEL_PORT:  cur_val = output_latch_reg;
      gpcn_pkg::SEL_ODC:   cur_val = open_drain_ctl_reg;
      gpcn_pkg::SEL_ANSEL: cur_val = analog_select_reg;
      gpcn_pkg::SEL_CNEN:  cur_val = change_irq_enable_reg;
      gpcn_pkg::SEL_PU:    cur_val = weak_pullup_enable_reg;
      gpcn_pkg::SEL_PD:    cur_val = weak_pulldown_enable_reg;
      default:             cur_val = gpcn_pkg::ZERO_RST;
    endcase
  end

  gpcn_bitop u_bitop (
    .i_op    (i_req.op),
    .i_cur   (cur_val),
    .i_wdata (i_req.wdata),
    .o_next  (next_val)
  );

  assign wr_dir = i_req.wr && (i_req.sel == gpcn_pkg::SEL_DIR);
  // Pin level writes land in the latch
  assign wr_lat = i_req.wr && ((i_req.sel == gpcn_pkg::SEL_LAT) ||
                               (i_req.sel == gpcn_pkg::SEL_PORT));

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      direction_reg <= gpcn_pkg::DIR_RST;
    end else if (wr_dir) begin
      direction_reg <= next_val;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      output_latch_reg <= gpcn_pkg::ZERO_RST;
    end else if (wr_lat) begin
      output_latch_reg <= next_val;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      open_drain_ctl_reg       <= gpcn_pkg::ZERO_RST;
      analog_select_reg        <= gpcn_pkg::ANSEL_RST;
      change_irq_enable_reg    <= gpcn_pkg::ZERO_RST;
      weak_pullup_enable_reg   <= gpcn_pkg::ZERO_RST;
      weak_pulldown_enable_reg <= gpcn_pkg::ZERO_RST;
    end else if (i_req.wr) begin
      case (i_req.sel)
        gpcn_pkg::SEL_ODC:   open_drain_ctl_reg       <= next_val;
        gpcn_pkg::SEL_ANSEL: analog_select_reg        <= next_val;
        gpcn_pkg::SEL_CNEN:  change_irq_enable_reg    <= next_val;
        gpcn_pkg::SEL_PU:    weak_pullup_enable_reg   <= next_val;
        gpcn_pkg::SEL_PD:    weak_pulldown_enable_reg <= next_val;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Input synchroniser
  // ------------------------------------------------------------
  logic [15:0] pin_meta;
  logic [15:0] pin_sync;
  logic [15:0] pin_last;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_meta <= gpcn_pkg::ZERO_RST;
      pin_sync <= gpcn_pkg::ZERO_RST;
      pin_last <= gpcn_pkg::ZERO_RST;
    end else begin
      pin_meta <= i_pin_in;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  logic [15:0] analog_in;
  assign analog_in = analog_select_reg & direction_reg;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pin_out   <= gpcn_pkg::ZERO_RST;
      o_pin_oe    <= gpcn_pkg::ZERO_RST;
      o_pullup_en <= gpcn_pkg::ZERO_RST;
      o_pulldn_en <= gpcn_pkg::ZERO_RST;
      o_analog_in <= gpcn_pkg::ZERO_RST;
    end else begin
      // Output pins drive the latch even with analog-select set
      o_pin_out   <= output_latch_reg & ~open_drain_ctl_reg;
      // Open drain enables the driver only for a low level
      o_pin_oe    <= ~direction_reg & ~(open_drain_ctl_reg & output_latch_reg);
      o_pullup_en <= weak_pullup_enable_reg;
      o_pulldn_en <= weak_pulldown_enable_reg;
      o_analog_in <= analog_in;
    end
  end

  // ------------------------------------------------------------
  // Read path and change notification
  // ------------------------------------------------------------
  logic [15:0] pin_value;
  logic [15:0] ref_level;
  logic [15:0] changed;
  logic        port_rd;

  assign pin_value = pin_sync & ~analog_in;
  assign port_rd   = i_req.rd && !i_req.alias_rd && (i_req.sel == gpcn_pkg::SEL_PORT);
  assign changed   = (pin_sync ^ ref_level) & change_irq_enable_reg;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= gpcn_pkg::ZERO_RST;
    end else if (i_req.rd) begin
      if (i_req.alias_rd) begin
        o_rdata <= gpcn_pkg::ZERO_RST;
      end else begin
        case (i_req.sel)
          gpcn_pkg::SEL_PORT: o_rdata <= pin_value;
          default:            o_rdata <= cur_val;
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ref_level <= gpcn_pkg::ZERO_RST;
    end else if (port_rd) begin
      ref_level <= pin_sync;
    end
  end

  // Sticky flags; a change seen in the read cycle survives the re-arm
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_change_status <= gpcn_pkg::ZERO_RST;
      o_change_irq    <= 1'b0;
    end else begin
      if (port_rd) begin
        o_change_status <= changed & (pin_sync ^ pin_last);
      end else begin
        o_change_status <= o_change_status | changed;
      end
      o_change_irq <= |changed;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_reset_dir_input: assert property (@(posedge i_core_clk)
    $rose(i_rstn) |-> direction_reg == gpcn_pkg::DIR_RST)
    else $error("direction not all inputs after reset");
  a_reset_ansel_ones: assert property (@(posedge i_core_clk)
    $rose(i_rstn) |-> analog_select_reg == gpcn_pkg::ANSEL_RST)
    else $error("analog select not all ones after reset");
  a_input_no_drive: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    ##1 ((($past(direction_reg) & o_pin_oe) == 16'h0000)))
    else $error("input pin driven");
  a_od_no_high: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    ##1 (((o_pin_oe & o_pin_out & $past(open_drain_ctl_reg)) == 16'h0000)))
    else $error("open drain pin driven high");
  a_od_release: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    ##1 (((o_pin_oe & $past(open_drain_ctl_reg) & $past(output_latch_reg)) == 16'h0000)))
    else $error("open drain pin not released for high");
  a_out_drives_latch: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    ##1 ((((o_pin_out ^ $past(output_latch_reg)) & $past(~direction_reg)
          & $past(~open_drain_ctl_reg)) == 16'h0000)))
    else $error("output pin not driving latch");
  a_port_wr_latch: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_req.wr && i_req.sel == gpcn_pkg::SEL_PORT && i_req.op == gpcn_pkg::OP_WRITE)
    |=> output_latch_reg == $past(i_req.wdata))
    else $error("pin level write missed latch");
  a_analog_read_zero: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (port_rd && !i_req.wr) |=> ((o_rdata & $past(analog_in)) == 16'h0000))
    else $error("analog pin read nonzero");
  a_set_alias_bits: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_req.wr && i_req.sel == gpcn_pkg::SEL_DIR && i_req.op == gpcn_pkg::OP_SET)
    |=> direction_reg == ($past(direction_reg) | $past(i_req.wdata)))
    else $error("set alias wrong");
  a_change_sticky: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (|changed && !port_rd) |=> ((o_change_status & $past(changed)) == $past(changed)))
    else $error("change flag lost");
  a_sync_delay: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    $past(i_rstn, 2) |-> (pin_sync == $past(i_pin_in, 2)))
    else $error("synchronizer delay wrong");
endmodule
`default_nettype wire

/* gpcn_pins.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------
// External parts and wiring on the port pins
// ------------------------------------------
module gpcn_pins (
  input  wire logic        i_core_clk,  // Clock
  input  wire logic [15:0] i_pin_out,   // Port drive value
  input  wire logic [15:0] i_pin_oe,    // Port drive enable
  input  wire logic [15:0] i_pullup_en, // Weak pull-up enables
  input  wire logic [15:0] i_pulldn_en, // Weak pull-down enables
  input  wire logic [15:0] i_ext_val,   // Value driven from outside
  input  wire logic [15:0] i_ext_oe,    // Outside drive enable
  output logic      [15:0] o_pin        // Resolved pin level
);
  logic [15:0] flt = 16'h0000;
  // Undriven pins without a pull wander every cycle
  always @(posedge i_core_clk) begin
    flt <= ~o_pin;
  end
  // Port drive wins; an open-drain release leaves the line to the outside
  assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_oe & i_ext_val)
    | (~i_pin_oe & ~i_ext_oe & (i_pullup_en | (~i_pulldn_en & flt)));
endmodule
`default_nettype wire

/* gpcn_port_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module gpcn_port_tb;
  logic                clk = 1'b0;
  logic                rstn = 1'b0;
  gpcn_pkg::gpcn_req_t req = '0;
  logic [15:0]         ev = 16'h0000, eo = 16'h0000, pin, pout, poe, rdat, pu, pd, an, cs;
  logic                irq, rd_seen = 1'b0;
  logic [15:0]         m [8];
  logic [15:0]         q [$];
  int                  num_errors = 0, n_compared = 0, seed = 14;

  always #10 clk = ~clk;
  gpcn_port dut (.i_core_clk(clk), .i_rstn(rstn), .i_req(req), .i_pin_in(pin),
    .o_pin_out(pout), .o_pin_oe(poe), .o_rdata(rdat), .o_pullup_en(pu), .o_pulldn_en(pd),
    .o_analog_in(an), .o_change_status(cs), .o_change_irq(irq));
  gpcn_pins ext (.i_core_clk(clk), .i_pin_out(pout), .i_pin_oe(poe), .i_pullup_en(pu),
    .i_pulldn_en(pd), .i_ext_val(ev), .i_ext_oe(eo), .o_pin(pin));
  // ----------------
  // Helpers
  // ----------------
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %0t: got %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic [15:0] op_f(logic [1:0] op, logic [15:0] c, logic [15:0] d);
    case (op)
      gpcn_pkg::OP_CLR: return c & ~d;
      gpcn_pkg::OP_SET: return c | d;
      gpcn_pkg::OP_INV: return c ^ d;
      default: return d;
    endcase
  endfunction
  function automatic logic [15:0] plv(logic [15:0] v);
    return ((m[0] & v) | (~m[0] & m[1] & (~m[3] | v))) & ~(m[4] & m[0]);
  endfunction
  task automatic idle(input int n);
    repeat (n) @(posedge clk) req <= '0;
  endtask
  task automatic wr(input logic [2:0] s, input logic [1:0] op, input logic [15:0] d);
    logic [2:0] t;
    t = (s == gpcn_pkg::SEL_PORT) ? gpcn_pkg::SEL_LAT : s;
    m[t] = op_f(op, m[t], d);
    @(posedge clk) req <= '{1'b1, 1'b0, 1'b0, s, op, d};
  endtask
  task automatic rdq(input logic [2:0] s, input logic al, input logic [15:0] e);
    q.push_back(e);
    @(posedge clk) req <= '{1'b0, 1'b1, al, s, 2'h0, 16'h0000};
  endtask
  task automatic finish_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Read data appears the cycle after the read strobe
  always @(negedge clk) begin
    if (rd_seen) check(rdat, q.pop_front());
    rd_seen = req.rd;
  end
  initial begin
    #200000;
    num_errors++;
    $display("BAD %0t: timeout", $time);
    finish_test;
  end
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    logic [15:0] d, v0, mk;
    for (int i = 0; i < 8; i++) m[i] = gpcn_pkg::ZERO_RST;
    m[0] = gpcn_pkg::DIR_RST;
    m[4] = gpcn_pkg::ANSEL_RST;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check(poe, 16'h0000);
    check(an, 16'hffff);
    for (int s = 0; s < 8; s++) if (s != 2) rdq(s[2:0], 1'b0, m[s]);
    idle(2);
    $display("reset values done");
    for (int op = 0; op < 4; op++) begin
      for (int s = 0; s < 8; s++) begin
        d = 16'($random(seed));
        if (s >= 6) d = d & m[0];
        wr(s[2:0], op[1:0], d);
      end
      idle(1);
      for (int s = 0; s < 8; s++) if (s != 2) rdq(s[2:0], 1'b0, m[s]);
      rdq(op[2:0], 1'b1, 16'h0000);
      idle(2);
      @(negedge clk);
      check(pu, m[6]);
      check(pd, m[7]);
      check(an, m[4] & m[0]);
    end
    $display("register access done");
    for (int k = 0; k < 3; k++) begin
      wr(3'h6, 2'h0, 16'h0000);
      wr(3'h7, 2'h0, 16'h0000);
      for (int s = 0; s < 5; s++) if (s != 2) wr(s[2:0], 2'h0, 16'($random(seed)));
      ev <= 16'($random(seed));
      eo <= m[0] | m[3];
      idle(4);
      @(negedge clk);
      check(poe, ~m[0] & (~m[3] | ~m[1]));
      check(pout & ~m[0], m[1] & ~m[0] & ~m[3]);
      rdq(3'h2, 1'b0, plv(ev));
      idle(1);
    end
    $display("pin drive done");
    wr(3'h0, 2'h2, 16'hffff);
    wr(3'h4, 2'h1, 16'hffff);
    wr(3'h6, 2'h0, 16'h0f00);
    wr(3'h7, 2'h0, 16'hf000);
    eo <= 16'h00ff;
    idle(4);
    rdq(3'h2, 1'b0, {8'h0f, ev[7:0]});
    wr(3'h6, 2'h0, 16'h0000);
    wr(3'h7, 2'h0, 16'h0000);
    eo <= 16'hffff;
    idle(2);
    $display("pulls done");
    for (int k = 0; k < 3; k++) begin
      v0 = ev;
      mk = 16'($random(seed));
      idle(4);
      rdq(3'h2, 1'b0, v0);
      wr(3'h5, 2'h0, mk);
      ev <= v0 ^ 16'($random(seed));
      idle(5);
      @(negedge clk);
      check(cs, (v0 ^ ev) & mk);
      check({15'h0000, irq}, {15'h0000, |((v0 ^ ev) & mk)});
      rdq(3'h2, 1'b0, ev);
      idle(3);
      @(negedge clk);
      check(cs, 16'h0000);
      check({15'h0000, irq}, 16'h0000);
    end
    $display("change notify done");
    finish_test;
  end
endmodule
`default_nettype wire
